// File: include/srs_pkg.sv
package srs_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int POR_TYP_US = 3000;
   localparam int POR_MIN_US = 1500;
   localparam int CLKREQ_DLY_US = 120;
   localparam int SLEEP_MIN_US = 4200;
   localparam int POR_TYP_CYC = POR_TYP_US * (CLK_HZ / 1000000);
   localparam int POR_MIN_CYC = POR_MIN_US * (CLK_HZ / 1000000);
   localparam int CLKREQ_DLY_CYC = CLKREQ_DLY_US * (CLK_HZ / 1000000);
   localparam int SLEEP_MIN_CYC = SLEEP_MIN_US * (CLK_HZ / 1000000);
   localparam int LPCLK_WIN_CYC = 64;
   localparam int CNT_W = 24;

   // ----------------------------------------
   // States and carried status
   // ----------------------------------------
   typedef enum logic [4:0] {
      ST_RESET = 5'h01,
      ST_WAKE = 5'h02,
      ST_SLEEP = 5'h04,
      ST_SELECT = 5'h08,
      ST_BOOT = 5'h10
   } srs_state_t;

   typedef struct packed {
      logic boot;
      logic ref_xtal;
      logic lp_internal;
   } srs_status_t;

endpackage

// File: core/srs_edge_mon.sv
`timescale 1ns/1ps
module srs_edge_mon #(
   parameter int WIN = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic sig,
   output logic seen,
   output logic done
);
   import srs_pkg::*;

   logic sig_q;
   logic seen_q;
   logic [15:0] cnt_q;
   wire logic toggle = sig ^ sig_q;
   wire logic win_end = (cnt_q == 16'(WIN - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sig_q <= 1'b0;
         seen_q <= 1'b0;
         cnt_q <= 16'h0000;
      end else begin
         sig_q <= sig;
         // Each sleep interval opens a fresh observation window
         if (!run) begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
         end else if (!done) begin
            cnt_q <= cnt_q + 16'h0001;
            if (toggle && cnt_q != 16'h0000) begin
               seen_q <= 1'b1;
            end
         end
      end
   end

   assign seen = seen_q;
   assign done = win_end;
endmodule

// File: core/srs_sequencer.sv
`timescale 1ns/1ps
// Contract
// - Global reset held while external reset or power-on reset asserted; later release wins.
// - Power-on reset lasts 3 ms typical, never under 1.5 ms, after supply passes.
// - External reset postpones startup; otherwise startup follows power-on reset end.
// - Clock-request output asserts about 120 us after reset release.
// - Stay in sleep at least 4.2 ms after reset release.
// - No external reference oscillator means crystal is the reference.
// - No toggles on low-power clock input selects internal low-power clock.
module srs_sequencer #(
   parameter int POR_CYC = srs_pkg::POR_TYP_CYC,
   parameter int CLKREQ_CYC = srs_pkg::CLKREQ_DLY_CYC,
   parameter int SLEEP_CYC = srs_pkg::SLEEP_MIN_CYC,
   parameter int LPWIN_CYC = srs_pkg::LPCLK_WIN_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CORE_SUPPLY_RAIL_OK,
   input wire logic RESET_N,
   input wire logic REF_OSC_PRESENT,
   input wire logic SLOW_SLEEP_CLOCK_IN,
   output logic GLOBAL_RESET,
   output logic CLK_REQ,
   output logic SLEEPING,
   output logic BOOT_START,
   output srs_pkg::srs_status_t STATUS
);
   import srs_pkg::*;

   // ----------------------------------------
   // Power-on reset timer
   // ----------------------------------------
   localparam int POR_SAFE = (POR_CYC < POR_MIN_CYC) ? POR_MIN_CYC : POR_CYC;
   logic [CNT_W-1:0] por_cnt_q;
   logic [CNT_W-1:0] por_cnt_d;
   logic por_active_q;
   logic por_active_d;
   wire logic supply_low = ~CORE_SUPPLY_RAIL_OK;
   wire logic por_done = (por_cnt_q == CNT_W'(POR_SAFE - 1));
   wire logic por_step = por_active_q & ~supply_low;

   // A supply dip restarts the full power-on interval
   assign por_cnt_d = supply_low ? '0 : (por_step ? por_cnt_q + CNT_W'(1) : por_cnt_q);
   assign por_active_d = supply_low | (por_active_q & ~por_done);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         por_cnt_q <= '0;
      end else begin
         por_cnt_q <= por_cnt_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         por_active_q <= 1'b1;
      end else begin
         por_active_q <= por_active_d;
      end
   end

   // ----------------------------------------
   // Global reset combine
   // ----------------------------------------
   // Supply loss holds reset at once, not one edge later via the timer flag
   wire logic glob_rst = por_active_q | supply_low | ~RESET_N;

   // ----------------------------------------
   // Sequence state machine
   // ----------------------------------------
   srs_state_t state_q;
   srs_state_t state_d;
   logic [CNT_W-1:0] seq_cnt_q;
   logic [CNT_W-1:0] seq_cnt_d;
   logic clkreq_q;
   logic clkreq_d;
   logic ref_xtal_q;
   logic ref_xtal_d;
   logic lp_int_q;
   logic lp_int_d;
   logic boot_pulse_q;
   logic boot_pulse_d;
   // Slow clock monitor results
   logic lp_seen;
   logic lp_done;

   wire logic in_wake = (state_q == ST_WAKE);
   wire logic in_doze = (state_q == ST_SLEEP);
   wire logic in_select = (state_q == ST_SELECT);
   wire logic in_boot = (state_q == ST_BOOT);
   wire logic in_sleep = in_wake | in_doze;
   wire logic req_due = (seq_cnt_q == CNT_W'(CLKREQ_CYC - 1));
   // Counter freezes at the sleep limit so sleep_due stays true
   wire logic sleep_due = (seq_cnt_q >= CNT_W'(SLEEP_CYC - 1));
   wire logic cnt_run = in_sleep & ~sleep_due;
   wire logic req_set = in_wake & req_due;
   wire logic sel_take = in_select & ~glob_rst;

   srs_edge_mon #(
      .WIN(LPWIN_CYC)
   ) u_lp_mon (
      .clk(CLK),
      .rst(RST),
      .run(in_sleep),
      .sig(SLOW_SLEEP_CLOCK_IN),
      .seen(lp_seen),
      .done(lp_done)
   );

   // Any global reset returns the sequence to its start
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RESET: begin
            if (!glob_rst) begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (req_due) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (sleep_due && lp_done) begin
               state_d = ST_SELECT;
            end
         end
         ST_SELECT: begin
            state_d = ST_BOOT;
         end
         ST_BOOT: begin
            state_d = ST_BOOT;
         end
         default: begin
            state_d = ST_RESET;
         end
      endcase
      if (glob_rst) begin
         state_d = ST_RESET;
      end
   end

   // ----------------------------------------
   // Counter and flag next values
   // ----------------------------------------
   assign seq_cnt_d = glob_rst ? '0 : (cnt_run ? seq_cnt_q + CNT_W'(1) : seq_cnt_q);
   assign clkreq_d = ~glob_rst & (clkreq_q | req_set);
   // Clock choices are latched once, as the sleep interval closes
   assign ref_xtal_d = sel_take ? ~REF_OSC_PRESENT : ref_xtal_q;
   assign lp_int_d = sel_take ? ~lp_seen : lp_int_q;
   assign boot_pulse_d = sel_take;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // One short register per next value; each takes its reset value on chip reset
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         seq_cnt_q <= '0;
      end else begin
         seq_cnt_q <= seq_cnt_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         clkreq_q <= 1'b0;
      end else begin
         clkreq_q <= clkreq_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_xtal_q <= 1'b0;
      end else begin
         ref_xtal_q <= ref_xtal_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         lp_int_q <= 1'b0;
      end else begin
         lp_int_q <= lp_int_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         boot_pulse_q <= 1'b0;
      end else begin
         boot_pulse_q <= boot_pulse_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign GLOBAL_RESET = glob_rst;
   assign CLK_REQ = clkreq_q;
   // Sleeping covers the wake-up wait as well as the sleep proper
   assign SLEEPING = in_sleep;
   assign BOOT_START = boot_pulse_q;
   assign STATUS = '{
      boot: in_boot,
      ref_xtal: ref_xtal_q,
      lp_internal: lp_int_q
   };
endmodule

// File: tb/srs_board.sv
`timescale 1ns/1ps
module srs_board (
   input logic clk,
   input logic lp_on,
   output logic lp_clk
);
   logic [2:0] div_q = 3'h0;
   always @(posedge clk) div_q <= div_q + 3'h1;
   // Fitted slow clock runs from power-up; a missing one stays flat
   assign lp_clk = lp_on & div_q[2];
endmodule

// File: tb/srs_chk_properties.sv
`timescale 1ns/1ps
module srs_chk #(parameter int CLKREQ_CYC = 20, parameter int SLEEP_CYC = 100) (
   input logic CLK, RST, CORE_SUPPLY_RAIL_OK, RESET_N, REF_OSC_PRESENT,
   input logic GLOBAL_RESET, CLK_REQ, SLEEPING, BOOT_START,
   input srs_pkg::srs_status_t STATUS
);
   import srs_pkg::*;
   localparam int RL = CLKREQ_CYC - 1;
   localparam int RH = CLKREQ_CYC + 2;
   localparam int SB = SLEEP_CYC - 2;
   localparam int SE = SLEEP_CYC + 4;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_rel; $fell(GLOBAL_RESET); endsequence
   sequence s_gone; $fell(SLEEPING) && !GLOBAL_RESET; endsequence
   property p_hold; !RESET_N |-> GLOBAL_RESET; endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_rel; s_rel |-> RESET_N && CORE_SUPPLY_RAIL_OK; endproperty
   a_rel: assert property (p_rel) else $error("release");
   property p_clr; GLOBAL_RESET [*2] |-> !CLK_REQ && !SLEEPING && !BOOT_START; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_req; disable iff (RST || GLOBAL_RESET) s_rel |-> ##[RL:RH] $rose(CLK_REQ);
   endproperty
   a_req: assert property (p_req) else $error("request");
   property p_slp; s_rel |=> SLEEPING [*8]; endproperty
   a_slp: assert property (p_slp) else $error("sleep");
   property p_end; disable iff (RST || GLOBAL_RESET) s_rel |-> ##[SB:SE] $fell(SLEEPING);
   endproperty
   a_end: assert property (p_end) else $error("sleep end");
   property p_boot; s_gone |-> ##[1:2] BOOT_START; endproperty
   a_boot: assert property (p_boot) else $error("boot");
   property p_sel; BOOT_START |-> ##[0:1] STATUS.boot && STATUS.ref_xtal == !REF_OSC_PRESENT;
   endproperty
   a_sel: assert property (p_sel) else $error("select");
endmodule
bind srs_sequencer srs_chk #(.CLKREQ_CYC(CLKREQ_CYC), .SLEEP_CYC(SLEEP_CYC)) srs_chk_inst (.*);

// File: tb/startup_reset_sequencer_bench.sv
`timescale 1ns/1ps
module startup_reset_sequencer_bench;
   import srs_pkg::*;
   localparam int RQ = 20;
   localparam int SL = 100;
   logic clk = 1'b0, rst = 1'b1, ok = 1'b0, rn = 1'b0, ref_on = 1'b0, lp_on = 1'b0;
   logic lp_clk, gr, cr, slp, bs;
   logic [16:0] lf = 17'h15b9d;
   srs_status_t st;
   srs_status_t exp_q[$];
   int fails = 0, tests_run = 0, n;
   always #20 clk = ~clk;
   srs_board srs_board_inst (.clk(clk), .lp_on(lp_on), .lp_clk(lp_clk));
   srs_sequencer #(.POR_CYC(37500), .CLKREQ_CYC(RQ), .SLEEP_CYC(SL)) srs_sequencer_inst (
      .CLK(clk), .RST(rst), .CORE_SUPPLY_RAIL_OK(ok), .RESET_N(rn), .REF_OSC_PRESENT(ref_on),
      .SLOW_SLEEP_CLOCK_IN(lp_clk), .GLOBAL_RESET(gr), .CLK_REQ(cr), .SLEEPING(slp),
      .BOOT_START(bs), .STATUS(st));
   function automatic logic [16:0] lfsr(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, got, lo);
      end
   endtask
   task automatic wt(input int w, input int lim);
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (n < lim && (w == 0 ? gr !== 1'b0 : w == 1 ? cr !== 1'b1 : bs !== 1'b1));
      if (n >= lim) begin
         fails++;
         close_out;
      end
   endtask
   task automatic run(input bit por);
      lf = lfsr(lf);
      exp_q.push_back({1'b1, ~lf[0], ~lf[1]});
      @(posedge clk);
      ref_on <= lf[0];
      lp_on <= lf[1];
      ok <= !por;
      rn <= 1'b1;
      @(posedge clk);
      ok <= 1'b1;
      n = 0;
      wt(0, 40000);
      if (por) chk(n, 37499, 37502);
      n = 0;
      wt(1, 200);
      chk(n, RQ - 1, RQ + 2);
      wt(2, 400);
      chk(n, SL - 1, SL + 4);
      chk(st, exp_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      @(posedge clk);
      rn <= 1'b0;
      @(posedge clk);
      #1;
      chk({slp, cr, gr}, 1, 1);
      $display("run done por %0d", por);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      ok <= 1'b1;
      repeat (38000) @(posedge clk);
      #1;
      chk(gr, 1, 1);
      repeat (3) run(1'b0);
      run(1'b1);
      close_out;
   end
endmodule
